// file: src/mic_defines.vh
// Constants for the interrupt controller: offsets, bit positions, resets.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef MIC_DEFINES_VH
`define MIC_DEFINES_VH
// Register word indices (printed offsets are not all multiples of four,
// so they are indices and the byte address is four times the index)
`define MIC_IDX_FLAGS      8'hc8
`define MIC_IDX_ENABLE     8'hc9
`define MIC_IDX_STACK      8'hdf
`define MIC_IDX_CORE       8'h10
// Field positions shared by flag and enable registers
`define MIC_BIT_EXT0       0
`define MIC_BIT_EXT1       1
`define MIC_BIT_EXT2       2
`define MIC_BIT_SERIAL     3
`define MIC_BIT_BASE_TMR   4
`define MIC_BIT_TMR_A      5
`define MIC_BIT_TMR_B      6
`define MIC_NUM_SRC        7
// Stack pointer register fields
`define MIC_BIT_GIE        7
`define MIC_SP_MSB         3
// Reset values
`define MIC_RST_FLAGS      7'h00
`define MIC_RST_ENABLE     7'h00
`define MIC_RST_SP         4'hf
`define MIC_RST_GIE        1'b0
// Vector address
`define MIC_VECTOR_ADDR    16'h0008
// AXI responses
`define MIC_RESP_OKAY      2'b00
`define MIC_RESP_SLVERR    2'b10
`endif

// file: src/mic_sync_fall.v
// Two-flop synchroniser with falling-edge detector for one pin.
// Assumes the pin is asynchronous to aclk and idles high.
`timescale 1ns/100ps
module mic_sync_fall (
  input  wire aclk,
  input  wire aresetn,
  input  wire pin_in,
  output reg  fall_q
);
  reg meta_q;   // First stage, read only by sync_q
  reg sync_q;   // Second stage
  reg prev_q;   // Delayed copy for edge detection

  // Synchronise, then flag a high-to-low step
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
      fall_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
      fall_q <= prev_q & ~sync_q;
    end
  end
endmodule

// file: src/mic_flag_bit.v
// One sticky request flag: hardware set beats software clear.
// Assumes set and clear pulses are on aclk.
`timescale 1ns/100ps
module mic_flag_bit (
  input  wire aclk,
  input  wire aresetn,
  input  wire set_evt,
  input  wire sw_we,
  input  wire sw_val,
  output reg  flag_q
);
  // Set wins over a coinciding write of zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (set_evt) begin
      flag_q <= 1'b1;
    end else if (sw_we) begin
      flag_q <= sw_val;
    end
  end
endmodule

// file: src/mic_top.v
// Interrupt controller top: flags, enables, global enable, vectoring.
// Assumes internal events are one-cycle pulses on aclk, pins asynchronous,
// and the core sequencer pulses take and return strobes.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "mic_defines.vh"

//Contract
// - Seven sources, four internal three external
// - External requests detected on falling edge
// - External request wakes from power-down
// - Event sets flag regardless of enable
// - Vector when flag, enable, global enable
// - Disabled source flags but never vectors
// - Global enable low blocks all vectoring
// - Take loads vector, stack grows one
// - Taking interrupt clears global enable
// - Return from interrupt sets global enable
// - Enable register layout, bit7 zero, reset
// - Flag register same layout, reset clear
// - Global enable bit7, pointer bits 3:0
// - Timer overflow sets flag regardless enable
module mic_top (
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // External request pins
  input  wire        ext_request_0,
  input  wire        ext_request_1,
  input  wire        ext_request_2,
  // Internal event pulses
  input  wire        serial_port_evt,
  input  wire        base_timer_ovf,
  input  wire        timer_a_ovf,
  input  wire        timer_b_ovf,
  // Core sequencer handshake
  input  wire        core_take,
  input  wire        return_from_irq,
  input  wire        power_down,
  output reg         irq_request_q,
  output reg         pc_load_q,
  output reg  [15:0] pc_vector_q,
  output reg         stack_push_q,
  output reg         wake_q
);
  // Write channel state
  localparam WS_IDLE = 3'b001;
  localparam WS_HAVE = 3'b010;
  localparam WS_RESP = 3'b100;

  reg  [2:0]  wstate_q;        // Write state, one-hot
  reg  [9:0]  waddr_q;         // Captured write index
  reg         waddr_ok_q;      // Write address captured
  reg  [31:0] wdata_q;         // Captured write data
  reg         wstrb0_q;        // Low byte lane enabled
  reg         wdata_ok_q;      // Write data captured
  reg  [6:0]  enable_q;        // Per-source enables
  reg  [3:0]  sp_q;            // Stack pointer
  reg         gie_q;           // Global enable
  reg  [6:0]  events;          // Set pulses per source
  wire [6:0]  flags;           // Flag bits from flag cells
  wire [2:0]  ext_fall;        // Falling edges of pins
  wire [2:0]  ext_pins;        // Pin bundle for generate
  reg         we_flags;        // Software write to flags
  reg         we_enable;       // Software write to enables
  reg         we_stack;        // Software write to stack reg
  wire        pending;         // Enabled request outstanding
  wire        take;            // Interrupt actually taken
  reg  [31:0] rd_word;         // Read mux value
  reg         rd_hit;          // Read address is mapped
  wire [9:0]  raddr_idx;       // Read index from byte address

  assign ext_pins = {ext_request_2, ext_request_1, ext_request_0};

  // Pin synchronisers with edge detect, one per external source
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ext
      mic_sync_fall u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_in  (ext_pins[gi]),
        .fall_q  (ext_fall[gi])
      );
    end
  endgenerate

  // Gather set pulses in register bit order
  always @* begin
    events = 7'h00;
    events[`MIC_BIT_EXT0]     = ext_fall[0];
    events[`MIC_BIT_EXT1]     = ext_fall[1];
    events[`MIC_BIT_EXT2]     = ext_fall[2];
    events[`MIC_BIT_SERIAL]   = serial_port_evt;
    events[`MIC_BIT_BASE_TMR] = base_timer_ovf;
    events[`MIC_BIT_TMR_A]    = timer_a_ovf;
    events[`MIC_BIT_TMR_B]    = timer_b_ovf;
  end

  // Write commit strobes, decoded from captured index
  always @* begin
    we_flags  = 1'b0;
    we_enable = 1'b0;
    we_stack  = 1'b0;
    if (wstate_q == WS_HAVE && wstrb0_q) begin
      we_flags  = (waddr_q == {2'b00, `MIC_IDX_FLAGS});
      we_enable = (waddr_q == {2'b00, `MIC_IDX_ENABLE});
      we_stack  = (waddr_q == {2'b00, `MIC_IDX_STACK});
    end
  end

  // Flag cells; vectoring never clears them, only software does
  generate
    for (gi = 0; gi < `MIC_NUM_SRC; gi = gi + 1) begin : g_flag
      mic_flag_bit u_flag (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set_evt (events[gi]),
        .sw_we   (we_flags),
        .sw_val  (wdata_q[gi]),
        .flag_q  (flags[gi])
      );
    end
  endgenerate

  // One shared vector, no hardware priority among sources
  assign pending = |(flags & enable_q);
  // Core take only counts while a request is offered
  assign take = core_take & irq_request_q & gie_q;

  // Enable register and stack pointer with global enable
  always @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= `MIC_RST_ENABLE;
      sp_q     <= `MIC_RST_SP;
      gie_q    <= `MIC_RST_GIE;
    end else begin
      if (we_enable) begin
        enable_q <= wdata_q[6:0];
      end
      // Return and take beat a software write in the same cycle
      if (take) begin
        gie_q <= 1'b0;
        sp_q  <= sp_q - 4'h1;
      end else if (return_from_irq) begin
        gie_q <= 1'b1;
        sp_q  <= sp_q + 4'h1;
      end else if (we_stack) begin
        gie_q <= wdata_q[`MIC_BIT_GIE];
        sp_q  <= wdata_q[`MIC_SP_MSB:0];
      end
    end
  end

  // Requests and vector load toward the core sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_request_q <= 1'b0;
      pc_load_q     <= 1'b0;
      pc_vector_q   <= `MIC_VECTOR_ADDR;
      stack_push_q  <= 1'b0;
      wake_q        <= 1'b0;
    end else begin
      // Drop request in the take cycle so it is not taken twice
      irq_request_q <= pending & gie_q & ~take & ~we_stack;
      pc_load_q     <= take;
      stack_push_q  <= take;
      pc_vector_q   <= `MIC_VECTOR_ADDR;
      // Any pin edge wakes, enabled or not
      wake_q        <= power_down & (|ext_fall);
    end
  end

  // AXI write: take address and data in either order, then respond
  always @(posedge aclk) begin
    if (!aresetn) begin
      wstate_q      <= WS_IDLE;
      waddr_q       <= 10'h000;
      waddr_ok_q    <= 1'b0;
      wdata_q       <= 32'h0000_0000;
      wstrb0_q      <= 1'b0;
      wdata_ok_q    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MIC_RESP_OKAY;
    end else begin
      case (wstate_q)
        WS_IDLE: begin
          s_axi_awready <= ~waddr_ok_q & ~(s_axi_awvalid & s_axi_awready);
          s_axi_wready  <= ~wdata_ok_q & ~(s_axi_wvalid & s_axi_wready);
          if (s_axi_awvalid & s_axi_awready) begin
            waddr_q    <= s_axi_awaddr[11:2];
            waddr_ok_q <= 1'b1;
          end
          if (s_axi_wvalid & s_axi_wready) begin
            wdata_q    <= s_axi_wdata;
            wstrb0_q   <= s_axi_wstrb[0];
            wdata_ok_q <= 1'b1;
          end
          if ((waddr_ok_q | (s_axi_awvalid & s_axi_awready)) &
              (wdata_ok_q | (s_axi_wvalid & s_axi_wready))) begin
            wstate_q      <= WS_HAVE;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
          end
        end
        WS_HAVE: begin
          // Commit happens this cycle via the strobes
          s_axi_bvalid <= 1'b1;
          if (waddr_q == {2'b00, `MIC_IDX_FLAGS} ||
              waddr_q == {2'b00, `MIC_IDX_ENABLE} ||
              waddr_q == {2'b00, `MIC_IDX_STACK}) begin
            s_axi_bresp <= `MIC_RESP_OKAY;
          end else begin
            s_axi_bresp <= `MIC_RESP_SLVERR;
          end
          wstate_q <= WS_RESP;
        end
        WS_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            waddr_ok_q   <= 1'b0;
            wdata_ok_q   <= 1'b0;
            wstate_q     <= WS_IDLE;
          end
        end
        default: begin
          wstate_q <= WS_IDLE;
        end
      endcase
    end
  end

  assign raddr_idx = s_axi_araddr[11:2];

  // Read mux; reserved bits and bit 7 of flags and enables read zero
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (raddr_idx == {2'b00, `MIC_IDX_FLAGS}) begin
      rd_word[6:0] = flags;
    end else if (raddr_idx == {2'b00, `MIC_IDX_ENABLE}) begin
      rd_word[6:0] = enable_q;
    end else if (raddr_idx == {2'b00, `MIC_IDX_STACK}) begin
      rd_word[`MIC_BIT_GIE]  = gie_q;
      rd_word[`MIC_SP_MSB:0] = sp_q;
    end else if (raddr_idx == {2'b00, `MIC_IDX_CORE}) begin
      rd_word[0] = irq_request_q;
      rd_word[1] = pending;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // AXI read: one cycle to accept, data registered the next
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `MIC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// file: test/mic_top_props.sv
// Checker for the interrupt controller top ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module mic_top_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        core_take,
  input wire        power_down,
  input wire        irq_request_q,
  input wire        pc_load_q,
  input wire [15:0] pc_vector_q,
  input wire        stack_push_q,
  input wire        wake_q
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Core asks while a request stands
  sequence s_take;
    core_take && irq_request_q;
  endsequence
  // Jump and push land together
  sequence s_served;
    pc_load_q && stack_push_q;
  endsequence
  chk_vector_fixed: assert property (pc_vector_q == 16'h0008)
    else $error("vector address wrong");
  chk_take_served: assert property (s_take |=> s_served)
    else $error("take not serviced");
  chk_load_cause: assert property (s_served |->
    $past(core_take) && $past(irq_request_q))
    else $error("load without request");
  chk_req_dropped: assert property (s_served |=> !irq_request_q[*2])
    else $error("request kept during service");
  chk_load_single: assert property (pc_load_q |=> !pc_load_q)
    else $error("load longer than a cycle");
  chk_push_pair: assert property (stack_push_q == pc_load_q)
    else $error("push and load apart");
  chk_wake_cause: assert property (wake_q |-> $past(power_down))
    else $error("wake outside power-down");
  chk_reset_quiet: assert property ($rose(aresetn) |->
    !irq_request_q[*3])
    else $error("request right after reset");
endmodule
bind mic_top mic_top_props mic_top_props_i (.aclk(aclk),
  .aresetn(aresetn), .core_take(core_take), .power_down(power_down),
  .irq_request_q(irq_request_q), .pc_load_q(pc_load_q),
  .pc_vector_q(pc_vector_q), .stack_push_q(stack_push_q),
  .wake_q(wake_q));

// file: test/mic_core_model.sv
// Behavioural core sequencer facing the controller.
// Assumes a service routine of fixed length that ends in a return.
`timescale 1ns/100ps
module mic_core_model (
  input  wire  aclk,
  input  wire  aresetn,
  input  wire  irq_request_q,
  input  wire  slow,
  output logic core_take,
  output logic return_from_irq
);
  initial begin
    core_take = 0;
    return_from_irq = 0;
  end
  // Take when asked, optionally late, then return
  always begin
    @(posedge aclk);
    if (aresetn && irq_request_q) begin
      repeat (slow ? 3 : 0) @(posedge aclk);
      core_take <= 1;
      @(posedge aclk);
      core_take <= 0;
      // Long service leaves room to clear the flag first
      repeat (40) @(posedge aclk);
      return_from_irq <= 1;
      @(posedge aclk);
      return_from_irq <= 0;
    end
  end
endmodule

// file: test/mic_top_tb.sv
// Self-checking bench for the interrupt controller.
// Assumes AXI4-Lite register access and the core model as partner.
`timescale 1ns/100ps
module mic_top_tb;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd_q, d;
  logic [1:0] bresp, rresp, r, wb;
  logic awr, wr_r, bv, arr, rv, take, ret, irq, pcl, push, wake;
  logic [15:0] pcv;
  logic [2:0] pins = 3'h7;
  logic [3:0] ev = 0;
  logic pd = 0, slow = 0;
  int fails = 0, checked = 0, loads = 0, wakes = 0, i, k, l0;
  localparam logic [11:0] FL = 12'h320, EN = 12'h324, SK = 12'h37c;
  always #12.5 aclk = ~aclk;
  mic_top mic_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd_q), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .ext_request_0(pins[0]),
    .ext_request_1(pins[1]), .ext_request_2(pins[2]),
    .serial_port_evt(ev[0]), .base_timer_ovf(ev[1]),
    .timer_a_ovf(ev[2]), .timer_b_ovf(ev[3]), .core_take(take),
    .return_from_irq(ret), .power_down(pd), .irq_request_q(irq),
    .pc_load_q(pcl), .pc_vector_q(pcv), .stack_push_q(push),
    .wake_q(wake));
  mic_core_model mic_core_model_i (.aclk(aclk), .aresetn(aresetn),
    .irq_request_q(irq), .slow(slow), .core_take(take),
    .return_from_irq(ret));
  // Count jumps and wake pulses
  always @(posedge aclk) begin
    if (pcl === 1'b1) loads++;
    if (wake === 1'b1) wakes++;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Write: both channels offered, bready held until answer
  // Leading edge keeps a strobe from being lowered and raised at once
  // Waits have no limit of their own; the hang guard ends a stall
  task wr(input logic [11:0] a, input logic [31:0] v);
    bit ga, gw;
    ga = 0;
    gw = 0;
    @(posedge aclk);
    awa <= a; wd <= v; awv <= 1; wv <= 1; br <= 1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      if (!ga && awr === 1'b1) begin
        awv <= 0;
        ga = 1;
      end
      if (!gw && wr_r === 1'b1) begin
        wv <= 0;
        gw = 1;
      end
    end
    do @(posedge aclk); while (bv !== 1'b1);
    wb = bresp;
    br <= 0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge aclk);
    ara <= a; arv <= 1; rr <= 1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge aclk); while (rv !== 1'b1);
    d = rd_q; r = rresp; rr <= 0;
  endtask
  // Pins fall and stay low for nine cycles; events are one-cycle pulses
  task fire(input int s);
    if (s < 3) pins[s] <= 0; else ev[s-3] <= 1;
    @(posedge aclk);
    ev <= 0;
    repeat (8) @(posedge aclk);
    pins <= 3'h7;
    @(posedge aclk);
  endtask
  initial begin
    void'($urandom(67457));
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(FL); chk(d, 0);
    rd(EN); chk(d, 0);
    rd(SK); chk(d, 32'h0000_000f);
    rd(12'h004); chk(d, 0); chk(r, 2'b10);
    wr(12'h004, 0); chk(wb, 2'b10);
    k = $urandom;
    wr(EN, k | 32'h80); chk(wb, 0);
    rd(EN); chk(d, k & 32'h7f);
    // Global enable on, so only the cleared enables keep the core quiet
    wr(EN, 0); wr(SK, 32'h8f); pd <= 1;
    for (i = 0; i < 7; i++) begin
      fire(i); rd(FL); chk(d, 32'h1 << i);
      wr(FL, 0);
    end
    chk(wakes, 3);
    chk(loads, 0);
    pd <= 0;
    wr(SK, 32'h0f); chk(wb, 0);
    wr(EN, 32'h7f); fire($urandom % 7); chk(loads, 0);
    // Request pending but not raised while global enable is low
    rd(12'h040); chk(d, 32'h2);
    wr(FL, 0);
    for (i = 0; i < 2; i++) begin
      slow <= i[0]; k = $urandom % 7; l0 = loads;
      wr(SK, 32'h8f); fire(k);
      while (loads == l0 && checked < 999) @(posedge aclk);
      chk(loads, l0 + 1);
      rd(SK); chk(d, 32'h0000_000e);
      rd(FL); chk(d, 32'h1 << k);
      wr(FL, 0); repeat (40) @(posedge aclk);
      rd(SK); chk(d, 32'h0000_008f);
    end
    wr(SK, 0);
    fork
      wr(FL, 0);
      begin
        // Pulse must stand at the very edge that commits the clear
        while (awr !== 1'b1 || awv !== 1'b1) @(posedge aclk);
        ev[0] <= 1;
        @(posedge aclk); ev[0] <= 0;
      end
    join
    rd(FL); chk(d, 32'h8);
    final_report;
  end
  // Hang guard
  initial begin
    #(25 * 20000);
    fails++;
    final_report;
  end
endmodule
